// [hw/uplcf_pkg.sv]
// constants for the usb port line, tuning, role and fifo port register slice
package uplcf_pkg;
  localparam logic [9:0] PORT0_BASE = 10'h000;
  localparam logic [9:0] PORT1_BASE = 10'h200;
  localparam logic [8:0] OFS_LINE_STATUS = 9'h019;
  localparam logic [8:0] OFS_TUNING = 9'h01b;
  localparam logic [8:0] OFS_ROLE = 9'h01f;
  localparam logic [8:0] OFS_FIFO_RD_LO = 9'h020;
  localparam logic [8:0] OFS_FIFO_RD_HI = 9'h021;
  localparam logic [8:0] OFS_FIFO_WR_LO = 9'h022;
  localparam logic [8:0] OFS_FIFO_WR_HI = 9'h023;
  localparam logic [8:0] OFS_SPEED_PICK = 9'h030;
  localparam int SLEW_LSB = 4;
  localparam int TERM_LSB = 0;
  localparam logic [7:0] TUNING_MASK = 8'h33;
  localparam logic [7:0] TUNING_RESET = 8'h00;
  localparam logic [7:0] ROLE_RESET = 8'h00;
  localparam logic [1:0] SPEED_RESET = 2'h1;
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_LS = 2'h3;
  localparam logic [1:0] LINE_ACTIVE = 2'h1;
  localparam logic [1:0] LINE_IDLE = 2'h0;
endpackage

// [hw/uplcf_regs.sv]
// register slice for one usb port: line state, tuning, role select, fifo ports
`timescale 1ns/1ps
module uplcf_regs #(
  parameter logic IS_PORT1 = 1'b0
) (
  input wire logic i_mclk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [9:0] i_addr, // register byte address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  input wire logic i_sleep, // chip in sleep state
  input wire logic [1:0] i_fs_line, // fs receiver dp/dm levels
  input wire logic [1:0] i_ls_line, // ls receiver dp/dm levels
  input wire logic i_hs_activity, // hs squelch says bus active
  output logic [1:0] o_speed_pick, // transceiver speed select
  output logic [1:0] o_hs_slew_level, // hs slew rate
  output logic [1:0] o_hs_termination_level, // hs termination level
  output logic o_role_bit, // 1 host, 0 device
  output logic o_clk_en_common, // clock gate enable, common block
  output logic o_clk_en_device, // clock gate enable, device block
  output logic o_clk_en_host, // clock gate enable, host block
  input wire logic [15:0] i_rd_fifo_data, // read fifo word at head
  input wire logic [1:0] i_rd_fifo_vld, // valid byte lanes of head word
  output logic o_rd_fifo_pop, // pop pulse to read fifo
  output logic [15:0] o_wr_fifo_data, // push data
  output logic [1:0] o_wr_fifo_be, // pushed byte lanes
  output logic o_wr_fifo_push, // push pulse to write fifo
  input wire logic i_wr_fifo_odd // write fifo sits on a byte boundary
);
  logic [7:0] tuning_q;
  logic [7:0] tuning_d;
  logic role_q;
  logic [1:0] speed_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rd_pop_q;
  logic [15:0] wr_data_q;
  logic [1:0] wr_be_q;
  logic wr_push_q;
  logic clk_dev_q;
  logic clk_host_q;
  logic [1:0] line_state;
  logic role_eff;

  function automatic logic hit(input logic [9:0] a, input logic [8:0] ofs, input logic p1);
    logic [9:0] base;
    base = p1 ? uplcf_pkg::PORT1_BASE : uplcf_pkg::PORT0_BASE;
    hit = (a == (base | {1'b0, ofs}));
  endfunction

  // address decode, port base applied
  wire sel_line = hit(i_addr, uplcf_pkg::OFS_LINE_STATUS, IS_PORT1);
  wire sel_tune = hit(i_addr, uplcf_pkg::OFS_TUNING, IS_PORT1);
  wire sel_role = hit(i_addr, uplcf_pkg::OFS_ROLE, IS_PORT1);
  wire sel_rd_lo = hit(i_addr, uplcf_pkg::OFS_FIFO_RD_LO, IS_PORT1);
  wire sel_rd_hi = hit(i_addr, uplcf_pkg::OFS_FIFO_RD_HI, IS_PORT1);
  wire sel_wr_lo = hit(i_addr, uplcf_pkg::OFS_FIFO_WR_LO, IS_PORT1);
  wire sel_wr_hi = hit(i_addr, uplcf_pkg::OFS_FIFO_WR_HI, IS_PORT1);
  wire sel_speed = hit(i_addr, uplcf_pkg::OFS_SPEED_PICK, IS_PORT1);

  // line state select by speed; fs and ls lines already carry se0/j/k/se1 codes
  assign line_state = (speed_q == uplcf_pkg::SPEED_FS) ? i_fs_line :
                      (speed_q == uplcf_pkg::SPEED_LS) ? i_ls_line :
                      (speed_q == uplcf_pkg::SPEED_HS) ?
                        (i_hs_activity ? uplcf_pkg::LINE_ACTIVE : uplcf_pkg::LINE_IDLE) :
                      uplcf_pkg::LINE_IDLE;

  assign role_eff = IS_PORT1 ? 1'b1 : role_q;
  assign tuning_d = i_wdata & uplcf_pkg::TUNING_MASK;

  // a pop only when the read lane holds data; high lane pops only if it was last valid
  wire rd_fifo_hit = i_rd & (sel_rd_lo | sel_rd_hi);
  wire [7:0] rd_lo_byte = i_rd_fifo_vld[0] ? i_rd_fifo_data[7:0] : 8'h00;
  wire [7:0] rd_hi_byte = i_rd_fifo_vld[1] ? i_rd_fifo_data[15:8] : 8'h00;

  always_comb begin
    rdata_d = 8'h00;
    if (sel_line) begin
      rdata_d = {6'h00, line_state};
    end else if (sel_tune) begin
      rdata_d = tuning_q;
    end else if (sel_role) begin
      rdata_d = {7'h00, role_eff};
    end else if (sel_rd_lo) begin
      rdata_d = rd_lo_byte;
    end else if (sel_rd_hi) begin
      rdata_d = rd_hi_byte;
    end else if (sel_speed) begin
      rdata_d = {6'h00, speed_q};
    end
  end

  // write port: each lane write pushes one byte; on boundary only low lane taken
  wire wr_lo = i_wr & sel_wr_lo;
  wire wr_hi = i_wr & sel_wr_hi & ~i_wr_fifo_odd;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tuning_q <= uplcf_pkg::TUNING_RESET;
      role_q <= IS_PORT1;
      speed_q <= uplcf_pkg::SPEED_RESET;
    end else if (i_wr) begin
      // writes work regardless of i_sleep
      if (sel_tune) begin
        tuning_q <= tuning_d;
      end
      if (sel_role) begin
        role_q <= IS_PORT1 | i_wdata[0];
      end
      if (sel_speed) begin
        speed_q <= i_wdata[1:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
      rd_pop_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rdata_d : 8'h00;
      rd_pop_q <= rd_fifo_hit & (sel_rd_lo ? i_rd_fifo_vld[0] : i_rd_fifo_vld[1]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_data_q <= 16'h0000;
      wr_be_q <= 2'h0;
      wr_push_q <= 1'b0;
    end else begin
      wr_push_q <= wr_lo | wr_hi;
      wr_be_q <= {wr_hi, wr_lo};
      if (wr_lo | wr_hi) begin
        wr_data_q <= {i_wdata, i_wdata};
      end
    end
  end

  // clock gate enables follow role; common on from the first clock after reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_dev_q <= 1'b0;
      clk_host_q <= 1'b0;
    end else begin
      clk_dev_q <= ~role_eff;
      clk_host_q <= role_eff;
    end
  end

  logic common_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      common_q <= 1'b0;
    end else begin
      common_q <= 1'b1;
    end
  end

  assign o_rdata = rdata_q;
  assign o_speed_pick = speed_q;
  assign o_hs_slew_level = tuning_q[uplcf_pkg::SLEW_LSB +: 2];
  assign o_hs_termination_level = tuning_q[uplcf_pkg::TERM_LSB +: 2];
  assign o_role_bit = role_q;
  assign o_clk_en_common = common_q;
  assign o_clk_en_device = clk_dev_q;
  assign o_clk_en_host = clk_host_q;
  assign o_rd_fifo_pop = rd_pop_q;
  assign o_wr_fifo_data = wr_data_q;
  assign o_wr_fifo_be = wr_be_q;
  assign o_wr_fifo_push = wr_push_q;

  wire unused_sleep = i_sleep;
endmodule

// [testbench/uplcf_checker.sv]
// checker for the usb port register slice
`timescale 1ns/1ps
module uplcf_checker (
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset
  input wire logic [9:0] i_addr, // address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [7:0] o_rdata, // read data
  input wire logic i_hs_activity, // hs activity
  input wire logic [1:0] o_speed_pick, // speed
  input wire logic [1:0] o_hs_slew_level, // slew
  input wire logic [1:0] o_hs_termination_level, // term
  input wire logic o_role_bit, // role
  input wire logic o_clk_en_device, // device gate
  input wire logic o_clk_en_host, // host gate
  input wire logic [1:0] i_rd_fifo_vld, // lanes
  input wire logic o_rd_fifo_pop, // pop
  input wire logic o_wr_fifo_push, // push
  input wire logic i_wr_fifo_odd // boundary
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_lo_read;
    i_rd && i_addr == 10'h020 && i_rd_fifo_vld[0];
  endsequence
  AST_DEV: assert property (!o_role_bit |=> o_clk_en_device && !o_clk_en_host) else $error("gate dev");
  AST_HOST: assert property (o_role_bit |=> o_clk_en_host && !o_clk_en_device) else $error("gate host");
  AST_HS: assert property (i_rd && i_addr == 10'h019 && o_speed_pick == 2'h0 |=>
    o_rdata == {7'h0, $past(i_hs_activity)}) else $error("hs line");
  AST_TUNE: assert property (i_wr && i_addr == 10'h01b |=>
    {o_hs_slew_level, o_hs_termination_level} == {$past(i_wdata[5:4]), $past(i_wdata[1:0])}) else $error("tune");
  AST_RSV: assert property (i_rd && i_addr == 10'h01f |=> o_rdata[7:1] == 7'h0) else $error("rsv");
  AST_POP: assert property (s_lo_read |=> o_rd_fifo_pop) else $error("pop");
  AST_NOPOP: assert property (i_rd && i_addr == 10'h021 && !i_rd_fifo_vld[1] |=> !o_rd_fifo_pop) else $error("np");
  AST_BND: assert property (i_wr && i_addr == 10'h023 && i_wr_fifo_odd |=> !o_wr_fifo_push) else $error("bnd");
endmodule
bind uplcf_regs uplcf_checker chk (.*);

// [testbench/uplcf_fifo_model.sv]
// far-side fifo model
`timescale 1ns/1ps
module uplcf_fifo_model (
  input wire logic i_mclk, // clock
  input wire logic i_bnd, // byte boundary
  input wire logic i_pop, // pop
  input wire logic i_push, // push
  input wire logic [15:0] i_wdata, // push data
  input wire logic [1:0] i_be, // push lanes
  output logic [15:0] o_data = 16'h1122, // head word
  output logic [1:0] o_vld, // valid lanes
  output logic o_odd, // write boundary
  output logic [7:0] o_last = 8'h00 // last byte in
);
  assign o_vld = i_bnd ? 2'h1 : 2'h3;
  assign o_odd = i_bnd;
  always @(posedge i_mclk) begin
    if (i_pop) o_data <= o_data + 16'h0101;
    if (i_push) o_last <= i_be[1] ? i_wdata[15:8] : i_wdata[7:0];
  end
endmodule

// [testbench/tb.sv]
// bench for the usb port register slice
`timescale 1ns/1ps
module tb;
  logic i_mclk = 0, rst_n = 0, wr = 0, rd = 0, slp = 0, hsa = 0, bnd = 0, role, cc, cd, ch, pop, push, odd;
  logic [9:0] a = 0;
  logic [7:0] wd = 0, v, rdat, last;
  logic [1:0] fs = 0, ls = 0, spd, sl, tm, vld, be;
  logic [15:0] fd, pd;
  int errors = 0, checks_done = 0;
  initial forever #4 i_mclk = ~i_mclk;
  uplcf_regs dut (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_sleep(slp), .i_fs_line(fs), .i_ls_line(ls), .i_hs_activity(hsa), .o_speed_pick(spd), .o_hs_slew_level(sl),
    .o_hs_termination_level(tm), .o_role_bit(role), .o_clk_en_common(cc), .o_clk_en_device(cd), .o_clk_en_host(ch),
    .i_rd_fifo_data(fd), .i_rd_fifo_vld(vld), .o_rd_fifo_pop(pop), .o_wr_fifo_data(pd), .o_wr_fifo_be(be),
    .o_wr_fifo_push(push), .i_wr_fifo_odd(odd));
  uplcf_fifo_model fifo (.i_mclk(i_mclk), .i_bnd(bnd), .i_pop(pop), .i_push(push), .i_wdata(pd), .i_be(be),
    .o_data(fd), .o_vld(vld), .o_odd(odd), .o_last(last));
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task put(input logic [9:0] ad, input logic [7:0] d);
    @(posedge i_mclk) {a, wd, wr} <= {ad, d, 1'b1};
    @(posedge i_mclk) wr <= 1'b0;
    #1;
  endtask
  task rchk(input logic [9:0] ad, input logic [7:0] e);
    @(posedge i_mclk) {a, rd} <= {ad, 1'b1};
    @(posedge i_mclk) rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task t_regs;
    rchk(10'h01b, 8'h00);
    rchk(10'h01f, 8'h00);
    rchk(10'h0ff, 8'h00);
    chk({spd, role, cc, cd, ch}, 6'h16);
    put(10'h01b, 8'hff);
    rchk(10'h01b, 8'h33);
    chk({sl, tm}, 4'hf);
    put(10'h01b, 8'h12);
    chk({sl, tm}, 4'h6);
    @(posedge i_mclk) slp <= 1'b1;
    put(10'h21f, 8'h01);
    rchk(10'h01f, 8'h00);
    put(10'h01f, 8'hff);
    rchk(10'h01f, 8'h01);
    chk({cc, cd, ch}, 3'h5);
    put(10'h01f, 8'h00);
    rchk(10'h01f, 8'h00);
    chk({cc, cd, ch}, 3'h6);
    $display("register test done");
  endtask
  task t_line;
    put(10'h030, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge i_mclk) hsa <= i[0];
      rchk(10'h019, {7'h0, i[0]});
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || i == 4) put(10'h030, i[2] ? 8'h03 : 8'h01);
      @(posedge i_mclk) {fs, ls} <= {i[1:0], ~i[1:0]};
      rchk(10'h019, {6'h0, i[2] ? ~i[1:0] : i[1:0]});
    end
    $display("line state test done");
  endtask
  task t_fifo;
    rchk(10'h020, 8'h22);
    chk(pop, 1'b1);
    rchk(10'h021, 8'h12);
    @(posedge i_mclk) bnd <= 1'b1;
    rchk(10'h021, 8'h00);
    chk(pop, 1'b0);
    rchk(10'h020, 8'h24);
    put(10'h022, 8'h5a);
    put(10'h023, 8'ha5);
    chk(last, 8'h5a);
    @(posedge i_mclk) bnd <= 1'b0;
    put(10'h023, 8'h3c);
    @(posedge i_mclk) #1 chk(last, 8'h3c);
    $display("fifo port test done");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000 errors++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    rst_n <= 1'b1;
    t_regs;
    t_line;
    t_fifo;
    complete_run;
  end
endmodule
